// ---- irq_matrix_map.vh ----
// constants for the dual-core interrupt source matrix
// assumes inclusion by bare name from the top design file of the matrix
`ifndef IRQ_MATRIX_MAP_VH
`define IRQ_MATRIX_MAP_VH

`define SRC_TOTAL        71
`define SRC_SHARED       67
`define SRC_PER_CORE     69
`define SRC_PER_CORE_W   7'd69
`define CORE_OUTPUTS     26
`define MAP_W            5
`define MAP_RESET        5'h1F
`define PIN_IRQ_NUM      22
`define PIN_NMI_NUM      23
`define WORD_W           32
`define WORD2_PAD        27
`define CORE_PRIMARY     1'b0
`define CORE_SECONDARY   1'b1

`endif

// ---- irq_or_select.v ----
// routing of one core's selectable sources onto its interrupt inputs
// assumes map values are stable flops of the caller; levels come straight from its input ports
`timescale 1ns/1ps

module irq_or_select #(
  parameter SRC_N = 69,
  parameter OUT_N = 26,
  parameter MAP_W = 5
) (
  input  wire [SRC_N-1:0]       sourceLevel,
  input  wire [SRC_N*MAP_W-1:0] routeFlat,
  output reg  [OUT_N-1:0]       coreIrq
);

  integer           s;
  reg   [MAP_W-1:0] sel;

  // --------------------------------------------------------------
  // map value picks the input, shared inputs are ORed
  // --------------------------------------------------------------
  always @* begin
    coreIrq = {OUT_N{1'b0}};
    sel     = {MAP_W{1'b0}};
    for (s = 0; s < SRC_N; s = s + 1) begin
      sel = routeFlat[s*MAP_W +: MAP_W];
      // values past the last input leave the source unrouted
      if (sel < OUT_N) begin
        coreIrq[sel] = coreIrq[sel] | sourceLevel[s]; // see (RULE11)
      end
    end
  end

endmodule // irq_or_select

// ---- dual_core_irq_source_matrix.v ----
// dual-core interrupt source matrix: sources to per-core interrupt inputs
// assumes all inputs synchronous to core_clk; map written through a write port
//
// Overview of operation
// (RULE1) seventy-one source lines come in, numbered from zero
// (RULE2) sixty-seven shared sources routable to either core independently
// (RULE3) four sources are core-specific, two per core, never crossing over
// (RULE4) primary pin irq and nmi sit at 22 and 23, primary only
// (RULE5) secondary pin irq and nmi sit at 22 and 23, secondary only
// (RULE6) each core selects among sixty-nine sources
// (RULE7) separate map register per source per core, writes never cross cores
// (RULE8) per-core status word 0 shows source levels at their number
// (RULE9) twenty-six interrupt outputs drive each core
// (RULE10) the two cores' allocations place no constraint on each other
// (RULE11) map value selects the core input; shared inputs are ORed
`timescale 1ns/1ps
`include "irq_matrix_map.vh"

module dual_core_irq_source_matrix #(
  parameter SRC_SHARED = `SRC_SHARED,
  parameter OUT_N      = `CORE_OUTPUTS
) (
  input  wire                   core_clk,
  input  wire                   reset,
  input  wire [SRC_SHARED-1:0]  sharedSource,
  input  wire                   pinIrqPrimary,
  input  wire                   pinNmiPrimary,
  input  wire                   pinIrqSecondary,
  input  wire                   pinNmiSecondary,
  input  wire                   routeWrite,
  input  wire                   routeCore,
  input  wire [6:0]             routeSource,
  input  wire [`MAP_W-1:0]      routeValue,
  input  wire                   routeReadCore,
  input  wire [6:0]             routeReadSource,
  output reg  [`MAP_W-1:0]      routeReadValue,
  output reg  [OUT_N-1:0]       primaryCoreIrq,
  output reg  [OUT_N-1:0]       secondaryCoreIrq,
  output reg  [`WORD_W-1:0]     primarySourceLevelWord0,
  output reg  [`WORD_W-1:0]     primarySourceLevelWord1,
  output reg  [`WORD_W-1:0]     primarySourceLevelWord2,
  output reg  [`WORD_W-1:0]     secondarySourceLevelWord0,
  output reg  [`WORD_W-1:0]     secondarySourceLevelWord1,
  output reg  [`WORD_W-1:0]     secondarySourceLevelWord2
);

  localparam SRC_N = `SRC_PER_CORE;

  integer i;
  integer j;

  reg  [`MAP_W-1:0]       primaryRoute   [0:SRC_N-1];
  reg  [`MAP_W-1:0]       secondaryRoute [0:SRC_N-1];
  wire [SRC_N-1:0]        primaryLevel;
  wire [SRC_N-1:0]        secondaryLevel;
  wire [SRC_N*`MAP_W-1:0] primaryFlat;
  wire [SRC_N*`MAP_W-1:0] secondaryFlat;
  wire [OUT_N-1:0]        next_primaryCoreIrq;
  wire [OUT_N-1:0]        next_secondaryCoreIrq;
  wire                    writeInRange;
  wire                    readInRange;
  reg                     writePrimary;
  reg                     writeSecondary;
  reg  [`MAP_W-1:0]       next_routeReadValue;
  wire [`WORD_W-1:0]      primaryTop;
  wire [`WORD_W-1:0]      secondaryTop;

  // --------------------------------------------------------------
  // per-core source vectors
  // --------------------------------------------------------------
  // shared lines fill every number but 22 and 23 on both cores;
  // each core's own pin pair fills 22 and 23 of that core only
  assign primaryLevel   = {sharedSource[SRC_SHARED-1:`PIN_IRQ_NUM], // see (RULE2)
                           pinNmiPrimary,                           // see (RULE4)
                           pinIrqPrimary,
                           sharedSource[`PIN_IRQ_NUM-1:0]};         // see (RULE6)
  assign secondaryLevel = {sharedSource[SRC_SHARED-1:`PIN_IRQ_NUM], // see (RULE1)
                           pinNmiSecondary,                         // see (RULE5)
                           pinIrqSecondary,
                           sharedSource[`PIN_IRQ_NUM-1:0]};         // see (RULE3)

  // --------------------------------------------------------------
  // map registers, one set per core
  // --------------------------------------------------------------
  assign writeInRange = routeSource < `SRC_PER_CORE_W;
  assign readInRange  = routeReadSource < `SRC_PER_CORE_W;

  // --------------------------------------------------------------
  // write decode, one strobe per core
  // --------------------------------------------------------------
  // numbers past the last source are dropped without effect
  always @* begin
    writePrimary   = 1'b0;
    writeSecondary = 1'b0;
    if (!routeWrite) begin
      writePrimary   = 1'b0;
      writeSecondary = 1'b0;
    end else if (!writeInRange) begin
      writePrimary   = 1'b0;
      writeSecondary = 1'b0;
    end else if (routeCore == `CORE_PRIMARY) begin
      writePrimary   = 1'b1;
    end else begin
      writeSecondary = 1'b1;
    end
  end

  // an in-range write lands in exactly one core's set
  always @(posedge core_clk) begin
    if (reset) begin
      for (i = 0; i < SRC_N; i = i + 1) begin
        primaryRoute[i] <= `MAP_RESET;
      end
    end else if (writePrimary) begin
      primaryRoute[routeSource] <= routeValue; // see (RULE7)
    end
  end

  // secondary set, same shape, own strobe
  always @(posedge core_clk) begin
    if (reset) begin
      for (j = 0; j < SRC_N; j = j + 1) begin
        secondaryRoute[j] <= `MAP_RESET;
      end
    end else if (writeSecondary) begin
      secondaryRoute[routeSource] <= routeValue; // see (RULE7)
    end
  end

  // --------------------------------------------------------------
  // map readback
  // --------------------------------------------------------------
  // zero for an unmapped number
  always @* begin
    next_routeReadValue = {`MAP_W{1'b0}};
    if (!readInRange) begin
      next_routeReadValue = {`MAP_W{1'b0}};
    end else if (routeReadCore == `CORE_PRIMARY) begin
      next_routeReadValue = primaryRoute[routeReadSource];
    end else begin
      next_routeReadValue = secondaryRoute[routeReadSource];
    end
  end

  // readback register
  always @(posedge core_clk) begin
    if (reset) begin
      routeReadValue <= {`MAP_W{1'b0}};
    end else begin
      routeReadValue <= next_routeReadValue;
    end
  end

  // --------------------------------------------------------------
  // routing, independent per core
  // --------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SRC_N; g = g + 1) begin : g_flat
      assign primaryFlat[g*`MAP_W +: `MAP_W]   = primaryRoute[g];
      assign secondaryFlat[g*`MAP_W +: `MAP_W] = secondaryRoute[g];
    end
  endgenerate

  irq_or_select #(
    .SRC_N (SRC_N),
    .OUT_N (OUT_N),
    .MAP_W (`MAP_W)
  ) u_primary_select (
    .sourceLevel (primaryLevel),
    .routeFlat   (primaryFlat),
    .coreIrq     (next_primaryCoreIrq)
  );

  // own map set and own selector keep the cores apart
  irq_or_select #(
    .SRC_N (SRC_N),
    .OUT_N (OUT_N),
    .MAP_W (`MAP_W)
  ) u_secondary_select (
    .sourceLevel (secondaryLevel),
    .routeFlat   (secondaryFlat),
    .coreIrq     (next_secondaryCoreIrq) // see (RULE10)
  );

  // --------------------------------------------------------------
  // registered outputs and status words
  // --------------------------------------------------------------
  // top word carries the last five sources, zero above them
  assign primaryTop   = {{`WORD2_PAD{1'b0}}, primaryLevel[SRC_N-1:64]};
  assign secondaryTop = {{`WORD2_PAD{1'b0}}, secondaryLevel[SRC_N-1:64]};

  // primary core side
  always @(posedge core_clk) begin
    if (reset) begin
      primaryCoreIrq          <= {OUT_N{1'b0}};
      primarySourceLevelWord0 <= 32'h00000000;
      primarySourceLevelWord1 <= 32'h00000000;
      primarySourceLevelWord2 <= 32'h00000000;
    end else begin
      primaryCoreIrq          <= next_primaryCoreIrq; // see (RULE9)
      primarySourceLevelWord0 <= primaryLevel[31:0];  // see (RULE8)
      primarySourceLevelWord1 <= primaryLevel[63:32];
      primarySourceLevelWord2 <= primaryTop;
    end
  end

  // secondary core side
  always @(posedge core_clk) begin
    if (reset) begin
      secondaryCoreIrq          <= {OUT_N{1'b0}};
      secondarySourceLevelWord0 <= 32'h00000000;
      secondarySourceLevelWord1 <= 32'h00000000;
      secondarySourceLevelWord2 <= 32'h00000000;
    end else begin
      secondaryCoreIrq          <= next_secondaryCoreIrq; // see (RULE9)
      secondarySourceLevelWord0 <= secondaryLevel[31:0];  // see (RULE8)
      secondarySourceLevelWord1 <= secondaryLevel[63:32];
      secondarySourceLevelWord2 <= secondaryTop;
    end
  end

endmodule // dual_core_irq_source_matrix

// ---- irq_matrix_properties.sv ----
// checker for the dual-core interrupt source matrix
// assumes binding to the matrix top, every port on core_clk
`timescale 1ns/1ps
module irq_matrix_properties #(
  parameter SRC_SHARED = 67,
  parameter OUT_N      = 26
) (
  input logic                  core_clk,
  input logic                  reset,
  input logic [SRC_SHARED-1:0] sharedSource,
  input logic                  pinIrqPrimary,
  input logic                  pinNmiPrimary,
  input logic                  pinIrqSecondary,
  input logic                  pinNmiSecondary,
  input logic                  routeWrite,
  input logic                  routeCore,
  input logic [6:0]            routeSource,
  input logic [4:0]            routeValue,
  input logic                  routeReadCore,
  input logic [6:0]            routeReadSource,
  input logic [4:0]            routeReadValue,
  input logic [OUT_N-1:0]      primaryCoreIrq,
  input logic [OUT_N-1:0]      secondaryCoreIrq,
  input logic [31:0]           primarySourceLevelWord0,
  input logic [31:0]           primarySourceLevelWord2,
  input logic [31:0]           secondarySourceLevelWord0
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire [31:0] lvlPri = {sharedSource[29:22], pinNmiPrimary, pinIrqPrimary, sharedSource[21:0]};
  wire [31:0] lvlSec = {sharedSource[29:22], pinNmiSecondary, pinIrqSecondary, sharedSource[21:0]};
  statusPri_a: assert property (!$past(reset) |-> primarySourceLevelWord0 == $past(lvlPri))
    else $error("primary level word wrong");
  statusSec_a: assert property (!$past(reset) |-> secondarySourceLevelWord0 == $past(lvlSec))
    else $error("secondary level word wrong");
  topWord_a: assert property (!$past(reset) |->
    primarySourceLevelWord2 == {27'h0, $past(sharedSource[66:62])}) else $error("top word wrong");
  resetClear_a: assert property ($fell(reset) |-> primaryCoreIrq == '0 &&
    secondaryCoreIrq == '0 && routeReadValue == 5'h00) else $error("outputs not clear");
  readRange_a: assert property (routeReadSource > 7'd68 |=> routeReadValue == 5'h00)
    else $error("unknown source read not zero");
  writeRead_a: assert property (routeWrite && routeSource < 7'd69 && routeReadCore == routeCore &&
    routeReadSource == routeSource ##1 !routeWrite && $stable(routeReadSource) && $stable(routeReadCore)
    |=> routeReadValue == $past(routeValue, 2)) else $error("map readback wrong");
  idlePri_a: assert property ((sharedSource == '0 && !pinIrqPrimary && !pinNmiPrimary)[*3]
    |=> primaryCoreIrq == '0) else $error("primary irq without source");
  idleSec_a: assert property ((sharedSource == '0 && !pinIrqSecondary && !pinNmiSecondary)[*3]
    |=> secondaryCoreIrq == '0) else $error("secondary irq without source");
  cover property (routeWrite && routeSource > 7'd68);
  cover property (pinIrqSecondary && sharedSource == '0 ##2 secondaryCoreIrq != '0);
  cover property (routeWrite ##1 routeWrite == 1'b0 ##1 routeReadValue != 5'h1F);
endmodule // irq_matrix_properties

// ---- irq_source_model.sv ----
// peripheral source model: levels of every interrupt source line
// assumes step is raised for one cycle by the bench
`timescale 1ns/1ps
module irq_source_model (
  input  logic        core_clk,
  input  logic        step,
  input  logic [1:0]  mode,
  input  logic [70:0] draw,
  output logic [66:0] sharedSource,
  output logic [3:0]  pins
);
  // -------------
  // level drivers
  // -------------
  initial begin
    sharedSource = 67'h0;
    pins = 4'h0;
  end
  always @(negedge core_clk) begin
    if (step) begin
      sharedSource <= (mode == 2'h1) ? draw[66:0] : 67'h0;
      pins <= (mode == 2'h1) ? draw[70:67] : (mode == 2'h2) ? 4'hC : 4'h0;
    end
  end
endmodule // irq_source_model

// ---- dual_core_irq_source_matrix_test.sv ----
// self-checking bench for the dual-core interrupt source matrix
// assumes the source model and the checker are compiled first
`timescale 1ns/1ps
module dual_core_irq_source_matrix_test;
  // -----
  // bench
  // -----
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        step = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [70:0] draw = 71'h0;
  logic        routeWrite = 1'b0;
  logic        routeCore = 1'b0;
  logic        routeReadCore = 1'b0;
  logic [6:0]  routeSource = 7'h00;
  logic [6:0]  routeReadSource = 7'h00;
  logic [4:0]  routeValue = 5'h00;
  logic [66:0] sharedSource;
  logic [3:0]  pins;
  logic [4:0]  routeReadValue;
  logic [25:0] primaryCoreIrq;
  logic [25:0] secondaryCoreIrq;
  logic [31:0] primarySourceLevelWord0;
  logic [31:0] primarySourceLevelWord1;
  logic [31:0] primarySourceLevelWord2;
  logic [31:0] secondarySourceLevelWord0;
  logic [31:0] secondarySourceLevelWord1;
  logic [31:0] secondarySourceLevelWord2;
  logic [4:0]  mapTbl [2][69];
  logic        rc;
  logic [6:0]  rs;
  int          errors = 0;
  int          checked = 0;
  int          cycles = 0;
  irq_source_model u_src (.core_clk, .step, .mode, .draw, .sharedSource, .pins);
  dual_core_irq_source_matrix u_dut (.core_clk, .reset, .sharedSource,
    .pinIrqPrimary(pins[0]), .pinNmiPrimary(pins[1]), .pinIrqSecondary(pins[2]),
    .pinNmiSecondary(pins[3]), .routeWrite, .routeCore, .routeSource, .routeValue,
    .routeReadCore, .routeReadSource, .routeReadValue, .primaryCoreIrq, .secondaryCoreIrq,
    .primarySourceLevelWord0, .primarySourceLevelWord1, .primarySourceLevelWord2,
    .secondarySourceLevelWord0, .secondarySourceLevelWord1, .secondarySourceLevelWord2);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      conclude();
    end
  end
  function automatic logic [68:0] expLvl(input logic c);
    return {sharedSource[66:22], c ? pins[3:2] : pins[1:0], sharedSource[21:0]};
  endfunction
  function automatic logic [25:0] expIrq(input logic c);
    logic [68:0] lv;
    logic [25:0] r;
    lv = {sharedSource[66:22], c ? pins[3:2] : pins[1:0], sharedSource[21:0]};
    r = 26'h0;
    for (int k = 0; k < 69; k++) if (mapTbl[c][k] < 5'h1A) r[mapTbl[c][k]] |= lv[k];
    return r;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic c, input logic [6:0] s, input logic [4:0] v);
    @(negedge core_clk);
    routeWrite = 1'b1;
    routeCore = c;
    routeSource = s;
    routeValue = v;
    if (s < 7'd69) mapTbl[c][s] = v;
    @(negedge core_clk);
    routeWrite = 1'b0;
  endtask
  task automatic settle(input logic [1:0] m);
    logic [95:0] ew;
    draw = 71'({$urandom, $urandom, $urandom});
    mode = m;
    @(posedge core_clk) step <= 1'b1;
    @(posedge core_clk) step <= 1'b0;
    repeat (3) @(negedge core_clk);
    cmp(primaryCoreIrq, expIrq(1'b0));
    cmp(secondaryCoreIrq, expIrq(1'b1));
    cmp(primarySourceLevelWord0, {sharedSource[29:22], pins[1:0], sharedSource[21:0]});
    ew = 96'(expLvl(1'b0));
    cmp(primarySourceLevelWord1, ew[63:32]);
    cmp(primarySourceLevelWord2, ew[95:64]);
    ew = 96'(expLvl(1'b1));
    cmp(secondarySourceLevelWord0, ew[31:0]);
    cmp(secondarySourceLevelWord1, ew[63:32]);
    cmp(secondarySourceLevelWord2, ew[95:64]);
  endtask
  task automatic conclude();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(51630));
    foreach (mapTbl[c, s]) mapTbl[c][s] = 5'h1F;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    @(negedge core_clk);
    cmp(routeReadValue, 5'h1F);
    wr(1'b0, 7'd22, 5'h00);
    wr(1'b1, 7'd22, 5'h01);
    wr(1'b1, 7'd23, 5'h01);
    settle(2'h2);
    foreach (mapTbl[c, s]) wr(c[0], 7'(s), 5'($urandom));
    repeat (30) begin
      rc = 1'($urandom);
      rs = 7'($urandom % 80);
      routeReadCore = rc;
      routeReadSource = rs;
      wr(rc, rs, 5'($urandom));
      repeat (2) @(negedge core_clk);
      cmp(routeReadValue, rs < 7'd69 ? mapTbl[rc][rs] : 5'h00);
      settle(2'h1);
    end
    @(negedge core_clk);
    reset = 1'b1;
    foreach (mapTbl[c, s]) mapTbl[c][s] = 5'h1F;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    routeReadCore = 1'b1;
    routeReadSource = 7'd68;
    repeat (2) @(negedge core_clk);
    cmp(routeReadValue, 5'h1F);
    settle(2'h1);
    settle(2'h0);
    conclude();
  end
endmodule // dual_core_irq_source_matrix_test
bind dual_core_irq_source_matrix irq_matrix_properties #(.SRC_SHARED(SRC_SHARED), .OUT_N(OUT_N))
  u_props (.core_clk, .reset, .sharedSource, .pinIrqPrimary, .pinNmiPrimary, .pinIrqSecondary,
  .pinNmiSecondary, .routeWrite, .routeCore, .routeSource, .routeValue, .routeReadCore,
  .routeReadSource, .routeReadValue, .primaryCoreIrq, .secondaryCoreIrq,
  .primarySourceLevelWord0, .primarySourceLevelWord2, .secondarySourceLevelWord0);
